// [src/wdtsm_pkg.sv]
/*
  wdtsm_pkg: constants for the watchdog timer with sleep modes.
  assumes a 10 MHz system clock and a Wishbone classic register bus.
*/
package wdtsm_pkg;
  // register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  // control field layout
  localparam int SWEN_BIT = 0;
  localparam int PS_LSB = 1;
  localparam int PS_W = 5;
  // reset values and top valid period code
  localparam logic [4:0] PS_RESET = 5'h0B;
  localparam logic [4:0] PS_MAX_CODE = 5'h12;
  localparam logic SWEN_RESET = 1'b0;
  // mode codes
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_SW = 2'b01;
  localparam logic [1:0] MODE_NOSLP = 2'b10;
  localparam logic [1:0] MODE_ON = 2'b11;
  // prescale base: code 0 is 1:32, i.e. 2**5 oscillator ticks
  localparam int PS_BASE_SHIFT = 5;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LFOSC_HZ = 31_000;
  localparam int BASE_TICK_MS = 1;
  localparam int LFOSC_BASE_TICKS = 32;
endpackage

// [src/wdtsm_top.sv]
/*
  wdtsm_top: watchdog counter, mode logic, sleep handling and Wishbone
  classic register slave. assumes the low-frequency oscillator, sleep state
  and start-up timer arrive as asynchronous pins; clear and reset requests
  come from the core on clk_i.
*/
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module wdtsm_top (
  input wire logic clk_i, // 10 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [1:0] mode_cfg_i, // watchdog_mode_config, static strap
  input wire logic lfosc_i, // low_freq_internal_osc pin
  input wire logic sleep_i, // device in sleep, asynchronous
  input wire logic ost_run_i, // oscillator_startup_timer running
  input wire logic osc_fail_i, // oscillator failure
  input wire logic clear_watchdog_instruction_i, // clear_watchdog_instruction pulse
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic wdt_reset_o, // one-cycle device reset request
  output logic wdt_wake_o, // one-cycle wake request
  output logic timeout_flag_o, // timeout_flag, low after a watchdog event
  output logic power_down_flag_o, // power_down_flag
  output logic wdt_active_o // watchdog running
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins
  logic [1:0] lf_sync_ff;
  logic [1:0] slp_sync_ff;
  logic [1:0] ost_sync_ff;
  logic [1:0] fail_sync_ff;
  logic lf_prev_ff;
  logic slp_prev_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lf_sync_ff <= 2'b00;
      slp_sync_ff <= 2'b00;
      ost_sync_ff <= 2'b00;
      fail_sync_ff <= 2'b00;
      lf_prev_ff <= 1'b0;
      slp_prev_ff <= 1'b0;
    end else begin
      lf_sync_ff <= {lf_sync_ff[0], lfosc_i};
      slp_sync_ff <= {slp_sync_ff[0], sleep_i};
      ost_sync_ff <= {ost_sync_ff[0], ost_run_i};
      fail_sync_ff <= {fail_sync_ff[0], osc_fail_i};
      lf_prev_ff <= lf_sync_ff[1];
      slp_prev_ff <= slp_sync_ff[1];
    end
  end

  wire logic sleep_w = slp_sync_ff[1];
  wire logic lf_tick_w = lf_sync_ff[1] & ~lf_prev_ff;
  wire logic slp_enter_w = sleep_w & ~slp_prev_ff;
  wire logic slp_exit_w = ~sleep_w & slp_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] ps_ff;
  logic swen_ff;

  wire logic bus_req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr_ctrl_w = bus_req_w & wb_we_i & wb_sel_i[0] & (wb_adr_i == wdtsm_pkg::ADDR_CTRL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_ff <= wdtsm_pkg::PS_RESET;
      swen_ff <= wdtsm_pkg::SWEN_RESET;
    end else if (wr_ctrl_w) begin
      ps_ff <= wb_dat_i[wdtsm_pkg::PS_LSB +: wdtsm_pkg::PS_W];
      swen_ff <= wb_dat_i[wdtsm_pkg::SWEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  function automatic logic mode_active(input logic [1:0] m, input logic sw, input logic slp);
    logic r;
    r = 1'b0;
    case (m)
      wdtsm_pkg::MODE_ON: r = 1'b1;
      wdtsm_pkg::MODE_NOSLP: r = ~slp;
      wdtsm_pkg::MODE_SW: r = sw;
      wdtsm_pkg::MODE_OFF: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  wire logic active_w = mode_active(mode_cfg_i, swen_ff, sleep_w);

  // limit = 2**(code+5) ticks; reserved codes fall back to 1:32
  wire logic [4:0] eff_ps_w = (ps_ff > wdtsm_pkg::PS_MAX_CODE) ? 5'h00 : ps_ff;
  wire logic [wdtsm_pkg::CNT_W-1:0] limit_w =
    wdtsm_pkg::CNT_W'(24'h00_0001 << (eff_ps_w + 5'(wdtsm_pkg::PS_BASE_SHIFT)));

  ////////////////////////////////////////////////////////////////////////////
  // counter
  logic [wdtsm_pkg::CNT_W-1:0] cnt_ff;
  logic [wdtsm_pkg::CNT_W-1:0] nxt_cnt;
  logic timeout_ff;

  // ost gates whenever it runs; held clear keeps wake-up from racing the clock
  wire logic clear_w = clear_watchdog_instruction_i | slp_enter_w | slp_exit_w | fail_sync_ff[1] |
    ~active_w | ost_sync_ff[1];
  wire logic hit_w = lf_tick_w & (cnt_ff + 24'h00_0001 >= limit_w);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clear_w || hit_w) begin
      nxt_cnt = wdtsm_pkg::CNT_ZERO;
    end else if (lf_tick_w) begin
      nxt_cnt = cnt_ff + 24'h00_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= wdtsm_pkg::CNT_ZERO;
      timeout_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      timeout_ff <= hit_w & ~clear_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and flags
  // flags go high on rst_i; after that a timeout, a clear or sleep entry (power-down flag only) moves them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_reset_o <= 1'b0;
      wdt_wake_o <= 1'b0;
      wdt_active_o <= 1'b0;
      timeout_flag_o <= 1'b1;
      power_down_flag_o <= 1'b1;
    end else begin
      wdt_reset_o <= timeout_ff & ~sleep_w;
      wdt_wake_o <= timeout_ff & sleep_w;
      wdt_active_o <= active_w;
      if (timeout_ff) begin
        timeout_flag_o <= 1'b0;
        power_down_flag_o <= ~sleep_w;
      end else if (clear_watchdog_instruction_i) begin
        timeout_flag_o <= 1'b1;
        power_down_flag_o <= 1'b1;
      end else if (slp_enter_w) begin
        power_down_flag_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, one-cycle answer
  wire logic [31:0] rd_ctrl_w = {26'h000_0000, ps_ff, swen_ff};
  wire logic [31:0] rd_stat_w = {29'h0000_0000, wdt_active_o, power_down_flag_o, timeout_flag_o};
  wire logic [31:0] rd_mux_w = (wb_adr_i == wdtsm_pkg::ADDR_CTRL) ? rd_ctrl_w :
    (wb_adr_i == wdtsm_pkg::ADDR_STAT) ? rd_stat_w : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req_w;
      wb_dat_o <= bus_req_w ? rd_mux_w : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_reset_ps_load: assert property (@(posedge clk_i) rst_i |=> ps_ff == 5'h0B)
    else $error("period select not loaded on reset");
  chk_off_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b00) |=> cnt_ff == 24'h00_0000)
    else $error("count moved in off mode");
  chk_on_mode_act: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b11) |-> active_w)
    else $error("always-on mode not active");
  chk_noslp_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b10 && sleep_w) |-> !active_w)
    else $error("mode 10 active in sleep");
  chk_sw_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b01) |-> active_w == swen_ff)
    else $error("mode 01 ignores enable bit");
  chk_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_watchdog_instruction_i |=> cnt_ff == 24'h00_0000)
    else $error("clear did not zero count");
  chk_ost_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ost_sync_ff[1] |=> cnt_ff == 24'h00_0000)
    else $error("count moved during start-up");
  chk_reserved_min: assert property (@(posedge clk_i) disable iff (rst_i)
    (ps_ff > 5'h12) |-> limit_w == 24'h00_0020)
    else $error("reserved code not minimum");
  chk_timeout_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (timeout_ff && !sleep_w) |=> wdt_reset_o && !timeout_flag_o)
    else $error("timeout awake gave no reset");
  chk_sleep_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (timeout_ff && sleep_w) |=> wdt_wake_o && !wdt_reset_o)
    else $error("sleep timeout did not wake");
  chk_timeout_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    timeout_ff |=> !timeout_ff)
    else $error("timeout longer than one cycle");
  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // counter behaviour between and at ticks
  chk_fail_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    fail_sync_ff[1] |=> cnt_ff == 24'h00_0000)
    else $error("count moved during oscillator failure");
  chk_slp_enter_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    slp_enter_w |=> cnt_ff == 24'h00_0000)
    else $error("count not cleared at sleep entry");
  chk_slp_exit_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    slp_exit_w |=> cnt_ff == 24'h00_0000)
    else $error("count not cleared at wake");
  chk_inactive_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    !active_w |=> cnt_ff == 24'h00_0000)
    else $error("count moved while disabled");
  chk_tick_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (lf_tick_w && !clear_w && !hit_w) |=> cnt_ff == $past(cnt_ff) + 24'h00_0001)
    else $error("tick did not advance count");
  chk_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!lf_tick_w && !clear_w) |=> cnt_ff == $past(cnt_ff))
    else $error("count moved without a tick");
  chk_hit_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (hit_w && !clear_w) |=> cnt_ff == 24'h00_0000 && timeout_ff)
    else $error("hit gave no timeout");
  chk_clear_beats: assert property (@(posedge clk_i) disable iff (rst_i)
    (hit_w && clear_w) |=> !timeout_ff)
    else $error("timeout despite clear");

  // period decode at fixed points
  chk_limit_default: assert property (@(posedge clk_i) disable iff (rst_i)
    (ps_ff == 5'h0B) |-> limit_w == 24'h01_0000)
    else $error("reset code not 1:65536");
  chk_limit_top: assert property (@(posedge clk_i) disable iff (rst_i)
    (ps_ff == 5'h12) |-> limit_w == 24'h80_0000)
    else $error("top code not 1:8388608");
  chk_limit_min: assert property (@(posedge clk_i) disable iff (rst_i)
    (ps_ff == 5'h00) |-> limit_w == 24'h00_0020)
    else $error("code 0 not 1:32");

  // flags and pulses
  chk_wake_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (timeout_ff && sleep_w) |=> !power_down_flag_o && !timeout_flag_o)
    else $error("wake flags wrong");
  chk_awake_pd: assert property (@(posedge clk_i) disable iff (rst_i)
    (timeout_ff && !sleep_w) |=> power_down_flag_o)
    else $error("reset flags wrong");
  chk_clr_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (clear_watchdog_instruction_i && !timeout_ff) |=> timeout_flag_o && power_down_flag_o)
    else $error("clear did not set flags");
  chk_enter_pd: assert property (@(posedge clk_i) disable iff (rst_i)
    (slp_enter_w && !timeout_ff && !clear_watchdog_instruction_i) |=> !power_down_flag_o)
    else $error("sleep entry left power-down flag high");
  chk_no_reset_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_wake_o |-> !wdt_reset_o)
    else $error("reset and wake together");
  chk_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_reset_o |=> !wdt_reset_o)
    else $error("reset request longer than one cycle");
  chk_wake_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_wake_o |=> !wdt_wake_o)
    else $error("wake request longer than one cycle");
  chk_active_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> wdt_active_o == $past(active_w))
    else $error("active output lags mode decode");

  // mode table corners
  chk_off_inactive: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b00) |-> !active_w)
    else $error("off mode active");
  chk_noslp_awake: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b10 && !sleep_w) |-> active_w)
    else $error("mode 10 idle while awake");
  chk_sw_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_cfg_i == 2'b01 && sleep_w) |-> active_w == swen_ff)
    else $error("sleep changed software mode");

  // register bus
  chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req_w |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wb_cyc_i || !wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_sel_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req_w && wb_we_i && !wb_sel_i[0]) |=> $stable(ps_ff))
    else $error("masked write changed period");
  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req_w && wb_adr_i == 4'h8) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  cov_reset_awake: cover property (@(posedge clk_i) wdt_reset_o);
  cov_wake_sleep: cover property (@(posedge clk_i) wdt_wake_o);
  cov_ctrl_write: cover property (@(posedge clk_i) wr_ctrl_w);
  cov_sw_mode_on: cover property (@(posedge clk_i) mode_cfg_i == 2'b01 && active_w);
  cov_reserved_code: cover property (@(posedge clk_i) ps_ff > 5'h12 && hit_w);

endmodule // wdtsm_top

// [test/wdtsm_core_model.sv]
/* wdtsm_core_model: stand-in for the core and the reset controller.
   makes oscillator ticks and clear pulses, counts reset and wake requests. */
`timescale 1ns/1ps
module wdtsm_core_model (
  input wire logic clk_i, // system clock
  input wire logic rst_req_i, // reset request from the watchdog
  input wire logic wake_i, // wake request from the watchdog
  output logic lfosc_o, // oscillator, idle low between bursts
  output logic clear_watchdog_instruction_o // clear instruction pulse
);
  int n_rst = 0;
  int n_wake = 0;
  initial lfosc_o = 1'b0;
  initial clear_watchdog_instruction_o = 1'b0;
  always @(posedge clk_i) begin
    if (rst_req_i === 1'b1) n_rst++;
    if (wake_i === 1'b1) n_wake++;
  end
  // four cycles a tick so no edge is lost in the synchroniser
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      lfosc_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      lfosc_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic clear();
    @(posedge clk_i);
    clear_watchdog_instruction_o <= 1'b1;
    @(posedge clk_i);
    clear_watchdog_instruction_o <= 1'b0;
  endtask
  task automatic take(output int r, output int w);
    r = n_rst;
    w = n_wake;
    n_rst = 0;
    n_wake = 0;
  endtask
endmodule // wdtsm_core_model

// [test/tb_watchdog_timer_with_sleep_modes.sv]
/* tb_watchdog_timer_with_sleep_modes: register, mode, sleep and timeout checks.
   assumes wdtsm_top and wdtsm_core_model on one 10 MHz clock. */
`timescale 1ns/1ps
module tb_watchdog_timer_with_sleep_modes;
  logic clk_i, rst_i, cyc, stb, we, slp, oscillator_startup_timer, fail, ack, rq, wk, lf, clr, tof, pdf, act;
  logic [3:0] sel;
  logic [1:0] mode;
  logic [3:0] adr;
  logic [31:0] dat, dato, q;
  logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
  int lens [4] = '{32, 64, 32, 32};
  int errors = 0;
  int n_tests = 0;
  wdtsm_top wdtsm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_cfg_i(mode), .lfosc_i(lf),
    .sleep_i(slp), .ost_run_i(oscillator_startup_timer), .osc_fail_i(fail), .clear_watchdog_instruction_i(clr), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dato), .wb_ack_o(ack), .wdt_reset_o(rq), .wdt_wake_o(wk),
    .timeout_flag_o(tof), .power_down_flag_o(pdf), .wdt_active_o(act));
  wdtsm_core_model core_inst (.clk_i(clk_i), .rst_req_i(rq), .wake_i(wk),
    .lfosc_o(lf), .clear_watchdog_instruction_o(clr));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request stands until ack is sampled high at a rising edge; the 20000-cycle time limit ends a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // a status read also checks the flag pins against the same value
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
    if (a == 4'h4) chk({29'h0000_0000, act, pdf, tof}, exp);
  endtask
  // pulses land a few cycles after the last tick; wait them out first
  task automatic ev(input int r, input int w);
    int a, b;
    repeat (8) @(posedge clk_i);
    core_inst.take(a, b);
    chk(a, r);
    chk(b, w);
  endtask
  task automatic cfg(input logic [1:0] m);
    @(posedge clk_i);
    rst_i <= 1'b1;
    mode <= m;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // {sleep, start-up, osc fail}; settle time covers the synchronisers
  task automatic pins(input logic [2:0] v);
    @(posedge clk_i);
    {slp, oscillator_startup_timer, fail} <= v;
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    {rst_i, cyc, stb, we, slp, oscillator_startup_timer, fail} = 7'h40;
    sel = 4'hf;
    mode = 2'h0;
    adr = 4'h0;
    dat = 32'h0000_0000;
    cfg(2'h0);
    rd(4'h0, 32'h0000_0016);
    @(posedge clk_i);
    sel <= 4'h0;
    wb(1'b1, 4'h0, 32'h0000_003f);
    rd(4'h0, 32'h0000_0016);
    @(posedge clk_i);
    sel <= 4'hf;
    wb(1'b1, 4'h0, 32'h0000_0001);
    rd(4'h4, 32'h0000_0003);
    core_inst.ticks(40);
    ev(0, 0);
    rd(4'h8, 32'h0000_0000);
    cfg(2'h1);
    rd(4'h4, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h0, {26'h000_0000, codes[i], 1'b1});
      core_inst.clear();
      core_inst.ticks(lens[i] - 1);
      ev(0, 0);
      core_inst.ticks(1);
      ev(1, 0);
      rd(4'h4, 32'h0000_0006);
    end
    wb(1'b1, 4'h0, 32'h0000_0001);
    core_inst.clear();
    core_inst.ticks(20);
    core_inst.clear();
    core_inst.ticks(20);
    ev(0, 0);
    rd(4'h4, 32'h0000_0007);
    pins(3'h4);
    core_inst.ticks(32);
    ev(0, 1);
    rd(4'h4, 32'h0000_0004);
    pins(3'h0);
    cfg(2'h2);
    wb(1'b1, 4'h0, 32'h0000_0000);
    pins(3'h4);
    core_inst.ticks(40);
    ev(0, 0);
    rd(4'h4, 32'h0000_0001);
    pins(3'h0);
    core_inst.ticks(32);
    ev(1, 0);
    cfg(2'h3);
    wb(1'b1, 4'h0, 32'h0000_0000);
    pins(3'h4);
    core_inst.ticks(32);
    ev(0, 1);
    pins(3'h2);
    core_inst.ticks(40);
    ev(0, 0);
    pins(3'h1);
    core_inst.ticks(40);
    ev(0, 0);
    pins(3'h0);
    core_inst.ticks(32);
    ev(1, 0);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule // tb_watchdog_timer_with_sleep_modes
